/* File: logic/css_regs.vh */
`ifndef CSS_REGS_VH
`define CSS_REGS_VH
// register byte offsets
`define CSS_CTRL_ADDR 12'h000
`define CSS_STAT_ADDR 12'h004
`define CSS_TXBUF_ADDR 12'h008
`define CSS_RXBUF_ADDR 12'h00c
// control fields
`define CSS_CTRL_TXEN 0
`define CSS_CTRL_RXEN 1
`define CSS_CTRL_EXTCLK 2
`define CSS_CTRL_POL 3
`define CSS_CTRL_RTSEN 4
`define CSS_CTRL_CTSEN 5
`define CSS_CTRL_RESET 6'h00
// status fields
`define CSS_STAT_TXEMPTY 0
`define CSS_STAT_RXDONE 1
`define CSS_STAT_OVERRUN 2
`define CSS_STAT_BUSY 3
`define CSS_STAT_RXREQ 4
// timing: half period of internal shift clock in ns
`define CSS_HALF_NS 80
`define CSS_CLK_NS 8
// half period in device clocks: 80 ns over 8 ns
`define CSS_HALF_CYC 8'h0a
`define CSS_FIFO_DEPTH 16
`define CSS_FIFO_AW 4
`endif

/* File: logic/css_fifo.v */
module css_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_reg;
    reg [AW:0] rd_reg;
    wire [AW:0] level = wr_reg - rd_reg;
    assign in_ready = (level != DEPTH[AW:0]);
    assign out_valid = (level != {(AW+1){1'b0}});
    assign out_data = mem[rd_reg[AW-1:0]];
    always @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= {(AW+1){1'b0}};
            rd_reg <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && in_ready) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule // css_fifo

/* File: logic/css_serial_port.v */
// Contract
// - external clock with rts enabled: rts low when ready, high when reception starts
// - internal shift clock: rts function leaves rts output untouched (idle high)
// - transmitter makes the clock; dummy data shifts out while receiving
// - internal clock starts on tx enable plus buffer write; external needs clock too
// - word completing with receive-complete set raises overrun, buffer overwritten
// - overrun leaves the receive request bit unchanged
// - rts goes low as soon as rx enable is set, whatever tx state
// - rts rises at reception start, falls at completion, per word
`include "css_regs.vh"
module css_serial_port (
    input wire CLK,
    input wire RST_N,
    input wire HSEL,
    input wire [11:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg [31:0] HRDATA,
    output wire HREADYOUT,
    output wire HRESP,
    input wire SHIFT_CLOCK_PIN_IN,
    output reg SHIFT_CLOCK_PIN_OUT,
    output wire SHIFT_CLOCK_PIN_OE,
    output reg SERIAL_OUT_PIN,
    input wire SERIAL_IN_PIN,
    input wire CLEAR_TO_SEND_INPUT_N,
    output wire REQUEST_TO_SEND_N
);
    localparam ST_IDLE = 2'b00;
    localparam ST_SHIFT = 2'b01;
    localparam [7:0] HALF = `CSS_HALF_CYC;

    reg [5:0] ctrl_reg;
    reg rx_done_reg;
    reg overrun_reg;
    reg rx_req_reg;
    reg [7:0] rx_buf_reg;
    reg [1:0] state_reg;
    reg [7:0] tx_sh_reg;
    reg [7:0] rx_sh_reg;
    reg [2:0] bit_reg;
    reg [7:0] div_reg;
    reg rts_busy_reg;
    reg wr_ph_reg;
    reg [11:0] addr_ph_reg;
    reg [2:0] sck_sync_reg;
    reg [1:0] cts_sync_reg;
    reg [1:0] sin_sync_reg;

    wire tx_en = ctrl_reg[`CSS_CTRL_TXEN];
    wire rx_en = ctrl_reg[`CSS_CTRL_RXEN];
    wire ext_clk = ctrl_reg[`CSS_CTRL_EXTCLK];
    wire pol = ctrl_reg[`CSS_CTRL_POL];
    wire rts_en = ctrl_reg[`CSS_CTRL_RTSEN];
    wire cts_en = ctrl_reg[`CSS_CTRL_CTSEN];

    // ahb address phase
    wire take = HSEL && HREADY && HTRANS[1];
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    wire wr_data = wr_ph_reg;
    wire rd_rx = take && !HWRITE && (HADDR == `CSS_RXBUF_ADDR);

    // tx buffer fifo
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire fifo_push = wr_data && (addr_ph_reg == `CSS_TXBUF_ADDR);
    wire start_ok;
    css_fifo #(.WIDTH(8), .DEPTH(`CSS_FIFO_DEPTH), .AW(`CSS_FIFO_AW)) u_fifo (
        .clk(CLK),
        .rst_n(RST_N),
        .in_valid(fifo_push && tx_en),
        .in_ready(fifo_in_ready),
        .in_data(HWDATA[7:0]),
        .out_valid(fifo_out_valid),
        .out_ready(start_ok),
        .out_data(fifo_out_data)
    );

    // synchronisers
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sck_sync_reg <= 3'h7;
            cts_sync_reg <= 2'h3;
            sin_sync_reg <= 2'h0;
        end else begin
            sck_sync_reg <= {sck_sync_reg[1:0], SHIFT_CLOCK_PIN_IN};
            cts_sync_reg <= {cts_sync_reg[0], CLEAR_TO_SEND_INPUT_N};
            sin_sync_reg <= {sin_sync_reg[0], SERIAL_IN_PIN};
        end
    end
    // polarity 0: idle high, data out on falling edge, sampled on rising
    wire sck_a = sck_sync_reg[1] ^ pol;
    wire sck_b = sck_sync_reg[2] ^ pol;
    wire ext_fall = sck_b && !sck_a;
    wire ext_rise = !sck_b && sck_a;

    wire cts_ok = !cts_en || !cts_sync_reg[1];
    assign start_ok = (state_reg == ST_IDLE) && tx_en && cts_ok;

    // internal clock divider
    wire int_tick = (div_reg == HALF - 8'h01);
    wire int_lvl_hi = SHIFT_CLOCK_PIN_OUT ^ pol;
    wire shift_edge = ext_clk ? ext_fall : (int_tick && int_lvl_hi);
    wire samp_edge = ext_clk ? ext_rise : (int_tick && !int_lvl_hi);
    assign SHIFT_CLOCK_PIN_OE = !ext_clk;

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_IDLE;
            tx_sh_reg <= 8'h00;
            rx_sh_reg <= 8'h00;
            bit_reg <= 3'h0;
            div_reg <= 8'h00;
            SHIFT_CLOCK_PIN_OUT <= 1'b1;
            SERIAL_OUT_PIN <= 1'b1;
            rx_buf_reg <= 8'h00;
            rx_done_reg <= 1'b0;
            overrun_reg <= 1'b0;
            rx_req_reg <= 1'b0;
            rts_busy_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    div_reg <= 8'h00;
                    SHIFT_CLOCK_PIN_OUT <= !pol;
                    if (fifo_out_valid && start_ok) begin
                        tx_sh_reg <= fifo_out_data;
                        bit_reg <= 3'h0;
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    div_reg <= int_tick ? 8'h00 : div_reg + 8'h01;
                    if (!ext_clk && int_tick) begin
                        SHIFT_CLOCK_PIN_OUT <= !SHIFT_CLOCK_PIN_OUT;
                    end
                    if (shift_edge) begin
                        SERIAL_OUT_PIN <= tx_sh_reg[0];
                        tx_sh_reg <= {1'b1, tx_sh_reg[7:1]};
                        if (bit_reg == 3'h0 && rx_en) begin
                            rts_busy_reg <= 1'b1;
                        end
                    end
                    if (samp_edge) begin
                        rx_sh_reg <= {sin_sync_reg[1], rx_sh_reg[7:1]};
                        bit_reg <= bit_reg + 3'h1;
                        if (bit_reg == 3'h7) begin
                            state_reg <= ST_IDLE;
                            rts_busy_reg <= 1'b0;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
            // software clears first, so a same-cycle set wins
            if (wr_data && addr_ph_reg == `CSS_STAT_ADDR) begin
                if (HWDATA[`CSS_STAT_OVERRUN]) overrun_reg <= 1'b0;
                if (HWDATA[`CSS_STAT_RXREQ]) rx_req_reg <= 1'b0;
            end
            // receive completion, set beats clear
            if (samp_edge && state_reg == ST_SHIFT && bit_reg == 3'h7 && rx_en) begin
                rx_buf_reg <= {sin_sync_reg[1], rx_sh_reg[7:1]};
                rx_done_reg <= 1'b1;
                if (rx_done_reg && !rd_rx) begin
                    overrun_reg <= 1'b1;
                end else begin
                    rx_req_reg <= 1'b1;
                end
            end else if (rd_rx) begin
                rx_done_reg <= 1'b0;
            end
            if (!rx_en) begin
                rts_busy_reg <= 1'b0;
            end
        end
    end

    // rts: low as soon as rx enabled with external clock and rts enabled, high during a word
    assign REQUEST_TO_SEND_N = !(ext_clk && rts_en && rx_en && !rts_busy_reg);

    // register access
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= `CSS_CTRL_RESET;
            wr_ph_reg <= 1'b0;
            addr_ph_reg <= 12'h000;
            HRDATA <= 32'h00000000;
        end else begin
            wr_ph_reg <= take && HWRITE;
            addr_ph_reg <= HADDR;
            if (wr_data && addr_ph_reg == `CSS_CTRL_ADDR) begin
                ctrl_reg <= HWDATA[5:0];
            end
            HRDATA <= 32'h00000000;
            if (take && !HWRITE) begin
                case (HADDR)
                    `CSS_CTRL_ADDR: HRDATA <= {26'h0000000, ctrl_reg};
                    `CSS_STAT_ADDR: HRDATA <= {27'h0000000, rx_req_reg,
                        state_reg == ST_SHIFT, overrun_reg, rx_done_reg,
                        !fifo_out_valid};
                    `CSS_RXBUF_ADDR: HRDATA <= {24'h000000, rx_buf_reg};
                    default: HRDATA <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // css_serial_port

/* File: sim/css_sva.sv */
`include "css_regs.vh"
module css_sva (
    input wire CLK,
    input wire RST_N,
    input wire HSEL,
    input wire [11:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [31:0] HWDATA,
    input wire HREADYOUT,
    input wire HRESP,
    input wire SHIFT_CLOCK_PIN_OUT,
    input wire SHIFT_CLOCK_PIN_OE,
    input wire REQUEST_TO_SEND_N
);
    reg wr_reg;
    reg [5:0] ctl_reg;
    wire on = ctl_reg[2] & ctl_reg[4] & ctl_reg[1];
    wire sc = SHIFT_CLOCK_PIN_OUT;
    wire rts = REQUEST_TO_SEND_N;
    // shadow of the control register
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_reg <= 1'b0;
            ctl_reg <= 6'h00;
        end else begin
            wr_reg <= HSEL & HREADYOUT & HTRANS[1] & HWRITE & (HADDR == `CSS_CTRL_ADDR);
            ctl_reg <= wr_reg ? HWDATA[5:0] : ctl_reg;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    resp_ok_a: assert property (HREADYOUT && !HRESP) else $error("bad response");
    oe_mode_a: assert property (SHIFT_CLOCK_PIN_OE == !ctl_reg[2]) else $error("bad oe");
    rts_int_a: assert property (!ctl_reg[2] |-> rts) else $error("rts internal");
    rts_off_a: assert property (!on |-> rts) else $error("rts while disabled");
    rts_on_a: assert property ($rose(on) |-> !rts) else $error("rts late");
    rts_back_a: assert property ($rose(rts) && on |-> ##[1:300] !rts) else $error("rts stuck");
    clk_half_a: assert property (SHIFT_CLOCK_PIN_OE && $changed(sc) |=> $stable(sc) [*8])
        else $error("short half period");
    clk_still_a: assert property ((!ctl_reg[0] && SHIFT_CLOCK_PIN_OE) [*2] |=> $stable(sc))
        else $error("clock without enable");
    cover property ($rose(on));
    cover property ($rose(rts) && on);
    cover property (SHIFT_CLOCK_PIN_OE && $fell(sc));
endmodule // css_sva
bind css_serial_port css_sva u_css_sva (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .SHIFT_CLOCK_PIN_OUT(SHIFT_CLOCK_PIN_OUT), .SHIFT_CLOCK_PIN_OE(SHIFT_CLOCK_PIN_OE),
    .REQUEST_TO_SEND_N(REQUEST_TO_SEND_N));

/* File: sim/css_peer.sv */
module css_peer (
    input wire logic sco,
    input wire logic soe,
    input wire logic so,
    output logic sci,
    output logic si
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] txq = 8'h00;
    logic [7:0] rxq = 8'h00;
    logic [3:0] nb = 4'h0;
    wire sck = soe ? sco : sci;
    initial begin
        sci = 1'b1;
        si = 1'b1;
    end
    // lsb first, change on falling, sample on rising
    always @(negedge sck) begin
        si <= txq[nb[2:0]];
        nb <= nb + 4'h1;
    end
    always @(posedge sck) begin
        rxq <= {so, rxq[7:1]};
    end
    // clock stands still high outside frames
    task automatic burst(input int n);
        repeat (n * 8) begin
            #80 sci = 1'b0;
            #80 sci = 1'b1;
        end
    endtask
endmodule // css_peer

/* File: sim/tb_top.sv */
`include "css_regs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] A_CT = `CSS_CTRL_ADDR, A_ST = `CSS_STAT_ADDR;
    localparam logic [11:0] A_TX = `CSS_TXBUF_ADDR, A_RX = `CSS_RXBUF_ADDR;
    logic CLK = 1'b0, RST_N = 1'b0, hsel = 1'b0, hwrite = 1'b0, cts_n = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, q;
    logic hrdy, hresp, sco, soe, so, sci, si, rts_n;
    int n_fail = 0, n_checks = 0;
    always #4 CLK = ~CLK;
    css_serial_port u_css_serial_port (.CLK(CLK), .RST_N(RST_N), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .SHIFT_CLOCK_PIN_IN(sci),
        .SHIFT_CLOCK_PIN_OUT(sco), .SHIFT_CLOCK_PIN_OE(soe), .SERIAL_OUT_PIN(so),
        .SERIAL_IN_PIN(si), .CLEAR_TO_SEND_INPUT_N(cts_n), .REQUEST_TO_SEND_N(rts_n));
    css_peer u_css_peer (.sco(sco), .soe(soe), .so(so), .sci(sci), .si(si));
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge CLK); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge CLK); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task automatic poll(input int b);
        for (int i = 0; i < 600 && !(q[b] === 1'b1 && q[3] === 1'b0); i++)
            bus(1'b0, A_ST, 32'h0);
    endtask
    task automatic t_reset;
        rd(A_ST, 32'h1);
        bus(1'b1, 12'h010, 32'hffffffff);
        rd(12'h010, 32'h0);
        rd(A_CT, 32'h0);
    endtask
    task automatic t_int;
        u_css_peer.txq = 8'ha5;
        cts_n <= 1'b1;
        bus(1'b1, A_CT, 32'h33);
        @(negedge CLK);
        `CHK(rts_n, 1'b1)
        bus(1'b1, A_TX, 32'h3c);
        repeat (10) @(posedge CLK);
        rd(A_ST, 32'h0);
        cts_n <= 1'b0;
        q = 32'h0;
        poll(1);
        rd(A_ST, 32'h13);
        rd(A_RX, 32'ha5);
        `CHK(u_css_peer.rxq, 8'h3c)
        rd(A_ST, 32'h11);
        bus(1'b1, A_ST, 32'h10);
    endtask
    task automatic t_over;
        u_css_peer.txq = 8'h11;
        bus(1'b1, A_TX, 32'h1);
        q = 32'h0;
        poll(1);
        bus(1'b1, A_ST, 32'h10);
        u_css_peer.txq = 8'h22;
        bus(1'b1, A_TX, 32'h2);
        poll(2);
        rd(A_ST, 32'h7);
        rd(A_RX, 32'h22);
        bus(1'b1, A_ST, 32'h4);
        rd(A_ST, 32'h1);
    endtask
    task automatic t_ext;
        bus(1'b1, A_CT, 32'h16);
        @(negedge CLK);
        `CHK(rts_n, 1'b0)
        bus(1'b1, A_CT, 32'h17);
        u_css_peer.txq = 8'h5a;
        bus(1'b1, A_TX, 32'hff);
        repeat (40) @(posedge CLK);
        bus(1'b0, A_ST, 32'h0);
        `CHK(q[1], 1'b0)
        u_css_peer.burst(1);
        poll(1);
        `CHK(rts_n, 1'b0)
        rd(A_RX, 32'h5a);
        `CHK(u_css_peer.rxq, 8'hff)
        bus(1'b1, A_ST, 32'h10);
    endtask
    task automatic t_fill;
        bus(1'b1, A_CT, 32'h05);
        for (int i = 0; i < 18; i++)
            bus(1'b1, A_TX, i);
        rd(A_ST, 32'h8);
        u_css_peer.burst(17);
        repeat (10) @(posedge CLK);
        rd(A_ST, 32'h1);
        `CHK(u_css_peer.rxq, 8'h10)
    endtask
    task automatic close_out;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        t_reset;
        t_int;
        t_over;
        t_ext;
        t_fill;
        close_out;
    end
    initial begin
        #200000;
        n_fail++;
        close_out;
    end
endmodule // tb_top
